// file: hw/mrs_pkg.sv
// Package of constants and types for the reset sequencer
package mrs_pkg;
  // Machine cycle timing
  localparam int                OSC_PER_MC      = 12;
  localparam int                STATES_PER_MC   = 6;
  localparam int                SAMPLE_STATE    = 5;
  localparam int                SAMPLE_PHASE    = 2;
  localparam int                GATE_OSC_PERIODS = 1536;
  localparam int                MIN_RST_MC      = 2;
  // Register byte offsets
  localparam logic [7:0]        OFF_CTRL        = 8'h00;
  localparam logic [7:0]        OFF_STATUS      = 8'h04;
  localparam logic [7:0]        OFF_PORTS       = 8'h08;
  localparam logic [7:0]        OFF_SP          = 8'h0c;
  localparam logic [7:0]        OFF_SBSTAT      = 8'h10;
  localparam logic [7:0]        OFF_RAM         = 8'h80;
  // Field positions
  localparam int                CTRL_SWRST_BIT  = 0;
  localparam int                CTRL_POR_BIT    = 1;
  localparam int                ST_INTRST_BIT   = 0;
  localparam int                ST_PIN_BIT      = 1;
  localparam int                ST_GATE_BIT     = 2;
  localparam int                ST_PORTF_BIT    = 3;
  // Reset values
  localparam logic [7:0]        RST_ZERO        = 8'h00;
  localparam logic [7:0]        RST_SP          = 8'h07;
  localparam logic [7:0]        RST_SBSTAT      = 8'hf8;
  localparam logic [31:0]       RST_PORTS       = 32'hffffffff;
  localparam logic [1:0]        RESP_OKAY       = 2'b00;
  localparam logic [1:0]        RESP_SLVERR     = 2'b10;

  typedef enum logic [1:0] {MRS_POWERUP, MRS_GATING, MRS_RESET, MRS_RUN} mrs_state_e;

  typedef struct packed {
    logic       int_reset;
    logic       addr_latch_strobe;
    logic       program_store_strobe;
    logic       cpu_clk_en;
  } mrs_core_s;
endpackage

// file: hw/mrs_reset_sequencer.sv
// Reset sequencer for a small 8-bit controller, with AXI4-Lite status access
//
// Summary of operation
// - Internal reset comes from the reset pin or from a power-on event.
// - The reset pin is asynchronous and is synchronised before use.
// - The synchronised pin is sampled once per machine cycle at state 5 phase 2.
// - After a high sample, internal reset repeats every machine cycle until the pin is low.
// - Port pins take their reset level at once when the pin goes high, unsynchronised.
// - The port reset level is a build parameter, all ones by default.
// - While reset is active the address latch and program store strobes stay high.
// - Internal reset loads each listed register, stack pointer 07 and bus status f8.
// - Reset leaves the internal data RAM untouched; its power-up content is undefined.
// - After power-on the core clock stays gated for 1536 oscillator periods.
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mrs_reset_sequencer #(
  parameter logic [31:0] PORT_RESET_LEVEL = mrs_pkg::RST_PORTS,
  parameter int          GATE_CYCLES      = mrs_pkg::GATE_OSC_PERIODS,
  parameter int          RAM_WORDS        = 32
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              reset_pin,
  input  wire logic              power_on,
  input  wire logic [31:0]       port_drive,
  output logic [31:0]            port_latches,
  output mrs_pkg::mrs_core_s     core,
  output logic [7:0]             stack_pointer,
  output logic [7:0]             serial_bus_status,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  initial begin
    if (GATE_CYCLES < 1 || GATE_CYCLES > 65535 || RAM_WORDS < 1 || RAM_WORDS > 32) begin
      $error("mrs_reset_sequencer: unsupported parameter");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages
  logic [2:0] pin_sync;
  logic [2:0] por_sync;
  logic       pin_level;
  logic       por_level;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_sync <= 3'h0;
      por_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], reset_pin};
      por_sync <= {por_sync[1:0], power_on};
    end
  end

  // Change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_level <= 1'b0;
      por_level <= 1'b0;
    end else begin
      if (pin_sync[1] == pin_sync[2]) begin
        pin_level <= pin_sync[2];
      end
      if (por_sync[1] == por_sync[2]) begin
        por_level <= por_sync[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Machine cycle timing
  logic [3:0] osc_cnt;
  logic       sample_pt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= 4'h0;
    end else if (osc_cnt == 4'(mrs_pkg::OSC_PER_MC - 1)) begin
      osc_cnt <= 4'h0;
    end else begin
      osc_cnt <= osc_cnt + 4'h1;
    end
  end

  // State n phase p is period 2*(n-1)+(p-1)
  assign sample_pt = (osc_cnt == 4'(2 * (mrs_pkg::SAMPLE_STATE - 1)
                                    + mrs_pkg::SAMPLE_PHASE - 1));

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  mrs_pkg::mrs_state_e state;
  logic [15:0]         gate_cnt;
  logic                sampled_high;
  logic                sw_reset;
  logic                sw_por;
  logic                por_start;
  logic                por_prev;

  assign por_start = (por_level && !por_prev) || sw_por;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_prev <= 1'b0;
    end else begin
      por_prev <= por_level;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sampled_high <= 1'b0;
    end else if (sample_pt) begin
      sampled_high <= pin_level || sw_reset;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= mrs_pkg::MRS_POWERUP;
      gate_cnt <= 16'h0;
    end else begin
      case (state)
        mrs_pkg::MRS_POWERUP: begin
          gate_cnt <= 16'h0;
          state    <= mrs_pkg::MRS_GATING;
        end
        mrs_pkg::MRS_GATING: begin
          // Clock held off so the oscillator settles
          if (por_start) begin
            gate_cnt <= 16'h0;
          end else if (gate_cnt == 16'(GATE_CYCLES - 1)) begin
            state <= mrs_pkg::MRS_RESET;
          end else begin
            gate_cnt <= gate_cnt + 16'h1;
          end
        end
        mrs_pkg::MRS_RESET: begin
          if (por_start) begin
            gate_cnt <= 16'h0;
            state    <= mrs_pkg::MRS_GATING;
          end else if (sample_pt && !pin_level && !sw_reset) begin
            state <= mrs_pkg::MRS_RUN;
          end
        end
        mrs_pkg::MRS_RUN: begin
          if (por_start) begin
            gate_cnt <= 16'h0;
            state    <= mrs_pkg::MRS_GATING;
          end else if (sample_pt && (pin_level || sw_reset)) begin
            state <= mrs_pkg::MRS_RESET;
          end
        end
        default: begin
          state <= mrs_pkg::MRS_POWERUP;
        end
      endcase
    end
  end

  logic int_reset;
  assign int_reset = (state != mrs_pkg::MRS_RUN);

  // Strobes forced high in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core <= '{int_reset: 1'b1, addr_latch_strobe: 1'b1,
                program_store_strobe: 1'b1, cpu_clk_en: 1'b0};
    end else begin
      core.int_reset            <= int_reset;
      core.addr_latch_strobe    <= 1'b1;
      core.program_store_strobe <= int_reset;
      core.cpu_clk_en           <= (state == mrs_pkg::MRS_RESET) ||
                                   (state == mrs_pkg::MRS_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Port latches and reset-loaded registers
  logic [31:0] port_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || int_reset) begin
      port_reg <= PORT_RESET_LEVEL;
    end else begin
      port_reg <= port_drive;
    end
  end

  // Raw pin bypasses the synchroniser so ports react at once
  assign port_latches = reset_pin ? PORT_RESET_LEVEL : port_reg;

  logic       sp_wr;
  logic [7:0] sp_wdata;

  always_ff @(posedge aclk) begin
    if (!aresetn || int_reset) begin
      stack_pointer     <= mrs_pkg::RST_SP;
      serial_bus_status <= mrs_pkg::RST_SBSTAT;
    end else if (sp_wr) begin
      stack_pointer     <= sp_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Scratch RAM, untouched by internal reset
  logic [31:0] ram [RAM_WORDS];
  logic        ram_wr;
  logic [4:0]  ram_idx;
  logic [31:0] ram_wdata;

  always_ff @(posedge aclk) begin
    if (ram_wr) begin
      ram[ram_idx] <= ram_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read at a time
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_ok;
  logic [7:0]  wa;

  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_go         = aw_hold && w_hold && !s_axi_bvalid;
  assign wa            = aw_addr;
  assign wr_ok         = (wa == mrs_pkg::OFF_CTRL) || (wa == mrs_pkg::OFF_SP) ||
                         (wa >= mrs_pkg::OFF_RAM &&
                          9'(wa) < 9'(mrs_pkg::OFF_RAM) + 9'(4 * RAM_WORDS) &&
                          wa[1:0] == 2'b00);
  assign sp_wr         = wr_go && (wa == mrs_pkg::OFF_SP) && w_strb[0] && !int_reset;
  assign sp_wdata      = w_data[7:0];
  assign ram_wr        = wr_go && wr_ok && (wa >= mrs_pkg::OFF_RAM) && (&w_strb);
  assign ram_idx       = 5'(wa[6:2]);
  assign ram_wdata     = w_data;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
    end
  end

  // Software reset bits; one-shot power-on request self-clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_reset <= 1'b0;
      sw_por   <= 1'b0;
    end else begin
      sw_por <= wr_go && (wa == mrs_pkg::OFF_CTRL) && w_strb[0] &&
                w_data[mrs_pkg::CTRL_POR_BIT];
      if (wr_go && (wa == mrs_pkg::OFF_CTRL) && w_strb[0]) begin
        sw_reset <= w_data[mrs_pkg::CTRL_SWRST_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= mrs_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? mrs_pkg::RESP_OKAY : mrs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  logic [31:0] rd_val;
  logic        rd_ok;
  logic [7:0]  ra;
  assign ra = s_axi_araddr;

  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (ra == mrs_pkg::OFF_CTRL) begin
      rd_val[mrs_pkg::CTRL_SWRST_BIT] = sw_reset;
    end else if (ra == mrs_pkg::OFF_STATUS) begin
      rd_val[mrs_pkg::ST_INTRST_BIT] = int_reset;
      rd_val[mrs_pkg::ST_PIN_BIT]    = pin_level;
      rd_val[mrs_pkg::ST_GATE_BIT]   = (state == mrs_pkg::MRS_GATING);
      rd_val[mrs_pkg::ST_PORTF_BIT]  = (port_latches == PORT_RESET_LEVEL);
    end else if (ra == mrs_pkg::OFF_PORTS) begin
      rd_val = port_latches;
    end else if (ra == mrs_pkg::OFF_SP) begin
      rd_val[7:0] = stack_pointer;
    end else if (ra == mrs_pkg::OFF_SBSTAT) begin
      rd_val[7:0] = serial_bus_status;
    end else if (ra >= mrs_pkg::OFF_RAM &&
                 9'(ra) < 9'(mrs_pkg::OFF_RAM) + 9'(4 * RAM_WORDS) &&
                 ra[1:0] == 2'b00) begin
      rd_val = ram[5'(ra[6:2])];
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= mrs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? mrs_pkg::RESP_OKAY : mrs_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sample_once;
    @(posedge aclk) disable iff (!aresetn)
      sample_pt |=> !sample_pt [*8];
  endproperty
  a_sample_once: assert property (p_sample_once) else $error("sample twice in cycle");

  property p_mc_len;
    @(posedge aclk) disable iff (!aresetn)
      sample_pt |-> ##12 sample_pt;
  endproperty
  a_mc_len: assert property (p_mc_len) else $error("machine cycle not 12");

  property p_reapply;
    @(posedge aclk) disable iff (!aresetn)
      (sample_pt && pin_level && state == mrs_pkg::MRS_RUN) |=> int_reset;
  endproperty
  a_reapply: assert property (p_reapply) else $error("pin high sample not reset");

  property p_release;
    @(posedge aclk) disable iff (!aresetn)
      ($fell(int_reset)) |-> ($past(sample_pt) && !$past(pin_level));
  endproperty
  a_release: assert property (p_release) else $error("release without low sample");

  property p_ports;
    @(posedge aclk) disable iff (!aresetn)
      reset_pin |-> port_latches == PORT_RESET_LEVEL;
  endproperty
  a_ports: assert property (p_ports) else $error("ports not at reset level");

  property p_strobes;
    @(posedge aclk) disable iff (!aresetn)
      $past(int_reset) |-> core.addr_latch_strobe && core.program_store_strobe;
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobe low in reset");

  property p_regs;
    @(posedge aclk) disable iff (!aresetn)
      $past(int_reset) |-> stack_pointer == mrs_pkg::RST_SP
                           && serial_bus_status == mrs_pkg::RST_SBSTAT;
  endproperty
  a_regs: assert property (p_regs) else $error("reset values wrong");

  property p_gate;
    @(posedge aclk) disable iff (!aresetn)
      (state == mrs_pkg::MRS_GATING) |-> ##1 !core.cpu_clk_en;
  endproperty
  a_gate: assert property (p_gate) else $error("clock not gated");

  property p_por;
    @(posedge aclk) disable iff (!aresetn)
      por_start |=> state == mrs_pkg::MRS_GATING && gate_cnt == 16'h0;
  endproperty
  a_por: assert property (p_por) else $error("power-on not restarting");

  property p_sync;
    @(posedge aclk) disable iff (!aresetn)
      $changed(pin_level) |-> $past(pin_sync[2]) == $past(pin_sync[1]) &&
                              $past(pin_sync[2]) == pin_level;
  endproperty
  a_sync: assert property (p_sync) else $error("sync rule broken");

  c_run:   cover property (@(posedge aclk) disable iff (!aresetn) $fell(int_reset));
  c_rerst: cover property (@(posedge aclk) disable iff (!aresetn)
                           state == mrs_pkg::MRS_RUN ##1 state == mrs_pkg::MRS_RESET);
  c_wr:    cover property (@(posedge aclk) disable iff (!aresetn) wr_go && wr_ok);
endmodule

// file: bench/mrs_reset_source.sv
// Model of the external reset source: supervisor pulse or RC network
`timescale 1ns/1ps
module mrs_reset_source (
  input  wire logic aclk,
  output logic      reset_pin,
  output logic      power_on
);
  localparam int MIN_HOLD = mrs_pkg::MIN_RST_MC * mrs_pkg::OSC_PER_MC;

  // Pin has a pull-down, so a released pin reads low
  initial begin
    reset_pin = 1'b0;
    power_on  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supervisor pulse, never shorter than two machine cycles
  task automatic pulse(input int n);
    reset_pin <= 1'b1;
    repeat ((n < MIN_HOLD) ? MIN_HOLD : n) @(posedge aclk);
    reset_pin <= 1'b0;
  endtask

  // RC network at power-on: pin high over start-up plus two machine cycles
  task automatic rc_power_up(input int startup);
    power_on  <= 1'b0;
    @(posedge aclk);
    power_on  <= 1'b1;
    reset_pin <= 1'b1;
    repeat (startup + MIN_HOLD) @(posedge aclk);
    reset_pin <= 1'b0;
  endtask
endmodule

// file: bench/test_mcu_reset_sequencer.sv
// Self-checking testbench of the reset sequencer
`timescale 1ns/1ps
module test_mcu_reset_sequencer;
  localparam int          GATE  = 16;
  localparam logic [31:0] LEVEL = 32'hc3a5_0ff0;
  localparam logic [1:0]  OK    = mrs_pkg::RESP_OKAY;
  logic               aclk, aresetn, reset_pin, power_on;
  logic [31:0]        port_drive, port_latches, wdata, rdata, w, v;
  mrs_pkg::mrs_core_s core;
  logic [7:0]         stack_pointer, serial_bus_status, awaddr, araddr;
  logic               awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  logic [3:0]         wstrb;
  logic [1:0]         bresp, rresp;
  logic [33:0]        exp_q[$];
  logic [15:0]        lfsr_state;
  int                 failures, checks, n, m, k, drop, strobe_bad, early;

  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  mrs_reset_sequencer #(.PORT_RESET_LEVEL(LEVEL), .GATE_CYCLES(GATE)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .reset_pin(reset_pin), .power_on(power_on),
    .port_drive(port_drive), .port_latches(port_latches), .core(core),
    .stack_pointer(stack_pointer), .serial_bus_status(serial_bus_status),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  mrs_reset_source u_src (.aclk(aclk), .reset_pin(reset_pin), .power_on(power_on));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [31:0] v);
    lfsr_state = lfsr(lfsr_state);
    v[31:16] = lfsr_state;
    lfsr_state = lfsr(lfsr_state);
    v[15:0] = lfsr_state;
  endtask

  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] got);
    checks++;
    if (got !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic final_report;
    $display("Counts: %0d checks, %0d mismatches", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timed_out(input string what);
    failures++;
    $display("CHECK FAILED %s expected answer seen none", what);
    final_report();
  endtask

  // One bus transfer; the expected answer is queued for the monitor
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [33:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge aclk);
    if (wr) begin
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
    end
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if ((bvalid && bready) || (rvalid && rready)) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (i == 50) timed_out("bus response");
  endtask

  // Counts edges until a core bit takes a value; watches strobes meanwhile
  task automatic wait_core(input logic sel, input logic val, output int cyc);
    for (cyc = 0; cyc < 300; cyc++) begin
      @(posedge aclk);
      if (core.int_reset && !(core.addr_latch_strobe && core.program_store_strobe))
        strobe_bad++;
      if (!core.int_reset && !core.cpu_clk_en) early++;
      if ((sel ? core.cpu_clk_en : core.int_reset) === val) break;
    end
    if (cyc == 300) timed_out("core bit");
  endtask

  // Response monitor: oldest note against each answer
  always @(posedge aclk) begin
    if (rvalid && rready) chk("read answer", exp_q.size() ? exp_q.pop_front() : 'x, {rresp, rdata});
    if (bvalid && bready) chk("write answer", exp_q.size() ? exp_q.pop_front() : 'x, {bresp, 32'h0});
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn    = 1'b0;
    port_drive = 32'h0;
    awaddr     = 8'h00;
    araddr     = 8'h00;
    wdata      = 32'h0;
    wstrb      = 4'hf;
    awvalid    = 1'b0;
    wvalid     = 1'b0;
    bready     = 1'b0;
    arvalid    = 1'b0;
    rready     = 1'b0;
    lfsr_state = 16'hbf9c;
    repeat (8) @(posedge aclk);
    chk("ports held in reset", {2'b0, LEVEL}, {2'b0, port_latches});
    aresetn <= 1'b1;
    // Power-up: clock gated, then release once the pin is seen low
    wait_core(1'b1, 1'b1, n);
    chk("gating length ok", 34'h1, {33'h0, n >= GATE && n <= GATE + 3});
    wait_core(1'b0, 1'b0, m);
    chk("release after gating", 34'h1, {33'h0, m <= 14});
    $display("power-up test done");
    // Reset values, writable stack pointer, unmapped places
    axi(1'b0, mrs_pkg::OFF_SP, 32'h0, {OK, 24'h0, mrs_pkg::RST_SP});
    axi(1'b0, mrs_pkg::OFF_SBSTAT, 32'h0, {OK, 24'h0, mrs_pkg::RST_SBSTAT});
    axi(1'b1, mrs_pkg::OFF_SP, 32'h5a, {OK, 32'h0});
    axi(1'b0, mrs_pkg::OFF_SP, 32'h0, {OK, 32'h5a});
    axi(1'b0, 8'h40, 32'h0, {mrs_pkg::RESP_SLVERR, 32'h0});
    axi(1'b1, 8'h46, 32'h1, {mrs_pkg::RESP_SLVERR, 32'h0});
    rnd(w);
    axi(1'b1, mrs_pkg::OFF_RAM + 8'h04, w, {OK, 32'h0});
    $display("register test done");
    // Pin reset: ports at once, internal reset held while the pin is high
    rnd(v);
    port_drive <= v;
    @(posedge aclk);
    drop = 0;
    fork
      u_src.pulse(48);
      begin
        #1 chk("ports on pin high", {2'b0, LEVEL}, {2'b0, port_latches});
        wait_core(1'b0, 1'b1, n);
        chk("reset taken in time", 34'h1, {33'h0, n <= 17});
        for (k = 0; k < 60 && reset_pin; k++) begin
          @(posedge aclk);
          if (!core.int_reset && reset_pin) drop++;
        end
      end
    join
    chk("reset gaps while pin high", 34'h0, drop);
    wait_core(1'b0, 1'b0, m);
    chk("release after pin low", 34'h1, {33'h0, m <= 18});
    axi(1'b0, mrs_pkg::OFF_SP, 32'h0, {OK, 24'h0, mrs_pkg::RST_SP});
    axi(1'b0, mrs_pkg::OFF_RAM + 8'h04, 32'h0, {OK, w});
    $display("pin reset test done");
    // Power-on with RC network: gating starts again
    fork
      u_src.rc_power_up(40);
      begin
        wait_core(1'b1, 1'b0, n);
        wait_core(1'b1, 1'b1, n);
        chk("gating again", 34'h1, {33'h0, n >= GATE - 2 && n <= GATE + 3});
      end
    join
    wait_core(1'b0, 1'b0, m);
    chk("release after power-on", 34'h1, {33'h0, m <= 18});
    $display("power-on test done");
    // Running: ports follow the core
    for (k = 0; k < 4; k++) begin
      rnd(w);
      port_drive <= w;
      repeat (3) @(posedge aclk);
      chk("ports in run", {2'b0, w}, {2'b0, port_latches});
    end
    // Soft reset, then soft power-on, through the control register
    axi(1'b1, mrs_pkg::OFF_CTRL, 32'h1, {OK, 32'h0});
    wait_core(1'b0, 1'b1, n);
    axi(1'b0, mrs_pkg::OFF_STATUS, 32'h0, {OK, 32'h9});
    axi(1'b0, mrs_pkg::OFF_CTRL, 32'h0, {OK, 32'h1});
    axi(1'b1, mrs_pkg::OFF_CTRL, 32'h2, {OK, 32'h0});
    wait_core(1'b1, 1'b0, n);
    wait_core(1'b1, 1'b1, n);
    chk("soft power-on gating", 34'h1, {33'h0, n >= GATE - 2 && n <= GATE + 3});
    wait_core(1'b0, 1'b0, m);
    chk("stack pointer out", {26'h0, mrs_pkg::RST_SP}, {26'h0, stack_pointer});
    chk("bus status out", {26'h0, mrs_pkg::RST_SBSTAT}, {26'h0, serial_bus_status});
    $display("soft reset test done");
    chk("strobes low in reset", 34'h0, strobe_bad);
    chk("release during gating", 34'h0, early);
    chk("answers missing", 34'h0, exp_q.size());
    $display("run test done");
    final_report();
  end
endmodule
